/* logic/sdram_bank_params.svh */
// Timing, width and reset constants for the bank command tracker
`ifndef SDRAM_BANK_PARAMS_SVH
`define SDRAM_BANK_PARAMS_SVH
`define CLK_PERIOD_NS 25
`define RCD_NS 18
`define RP_NS 18
`define RC_NS 60
`define MRD_CK 2
`define XSR_NS 120
`define RCD_CYC ((`RCD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RP_CYC ((`RP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RC_CYC ((`RC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MRD_CYC (`MRD_CK)
`define XSR_CYC ((`XSR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NUM_BANKS 4
`define BANK_W 2
`define TMR_W 4
`define TMR_MAX 15
`define BURST_LEN_DEF 4
`define CAS_LAT_DEF 3
`define TMR_RST 4'h0
`define BANK_RST 2'h0
`endif

/* logic/sdram_bank_pkg.sv */
// Types for the bank command tracker
`include "sdram_bank_params.svh"
package sdram_bank_pkg;
   typedef enum logic [2:0] {
      B_IDLE = 3'b000,
      B_ACTIVATING = 3'b001,
      B_ACTIVE = 3'b010,
      B_READ = 3'b011,
      B_WRITE = 3'b100,
      B_PRECHARGING = 3'b101,
      B_READ_AP = 3'b110,
      B_WRITE_AP = 3'b111
   } bank_state_t;
   typedef enum logic [2:0] {
      D_NORMAL = 3'b000,
      D_REFRESH = 3'b001,
      D_MODE_LOAD = 3'b010,
      D_PRE_ALL = 3'b011,
      D_SELF_REF = 3'b100,
      D_SR_EXIT = 3'b101
   } dev_state_t;
   typedef enum logic [2:0] {
      C_MRS = 3'b000,
      C_REF = 3'b001,
      C_PRE = 3'b010,
      C_ACT = 3'b011,
      C_WR = 3'b100,
      C_RD = 3'b101,
      C_BST = 3'b110,
      C_NOP = 3'b111
   } cmd_t;
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } cmd_pins_t;
   typedef struct packed {
      bank_state_t st;
      logic [`TMR_W-1:0] tmr;
      logic [`TMR_W-1:0] brem;
   } bank_t;
   typedef bank_t [`NUM_BANKS-1:0] bank_vec_t;
   typedef bank_state_t [`NUM_BANKS-1:0] bank_states_t;
   typedef struct packed {
      logic cke_prev;
      dev_state_t dev;
      logic [`TMR_W-1:0] dev_tmr;
      logic [`BANK_W-1:0] last_bank;
      bank_vec_t bank;
      logic err;
      logic acc;
   } state_t;
endpackage

/* logic/sdram_bank_fsm.sv */
// Per-bank command decoder and state tracker of a four-bank SDRAM
`timescale 1ns/100ps
`default_nettype none
`include "sdram_bank_params.svh"

// Functional notes
// - Chip select high is inhibit; other inputs ignored, operations continue.
// - Select low with row, column and write strobes high is a no-operation.
// - Activate to an idle bank opens the addressed row.
// - Refresh and mode load are device-wide and need every bank idle.
// - Precharge to an idle bank changes nothing and acts as no-operation.
// - Read and write start bursts from active, read or write states.
// - Precharge closes the open row in one bank or all banks.
// - Precharge during a plain burst cuts it short and starts precharging.
// - Burst terminate stops the burst of the last read or write bank if plain; auto precharge bursts run on.
// - Self-refresh entry decodes as clock enable falls; all else only with it high twice and exit delay met.
// - Idle after precharge period; active after activate-to-access delay.
// - Activating bank accepts no own command until the access delay expires.
// - Precharging bank accepts no own command, then becomes idle.
// - Auto precharge bursts protect their bank until precharge period, then idle.
// - After refresh only inhibit or no-operation until refresh cycle time.
// - After mode load only inhibit or no-operation until mode-load delay.
// - After precharge-all only inhibit or no-operation until precharge period.
// - With the other bank idle, any command its own state allows is legal.
// - One bank busy without auto precharge leaves other banks commandable.
// - Activate or precharge to another bank leaves running bursts alone.
// - Read elsewhere ends a read after latency; write elsewhere ends it at once.
// - Read elsewhere ends a write at registration.
module sdram_bank_fsm
   import sdram_bank_pkg::*;
#(
   parameter int BURST_LEN = `BURST_LEN_DEF,
   parameter int CAS_LAT = `CAS_LAT_DEF
)
(
   input wire logic MCLK_I,
   input wire logic SYS_RST_I,
   input wire logic CKE_I,
   input wire cmd_pins_t CMD_N_I,
   input wire logic [`BANK_W-1:0] BA_I,
   input wire logic A10_I,
   output var bank_states_t BANK_STATE_O,
   output var dev_state_t DEV_STATE_O,
   output logic CMD_ERR_O,
   output logic CMD_ACC_O
);

   localparam logic [`TMR_W-1:0] RCD_N = `TMR_W'(`RCD_CYC);
   localparam logic [`TMR_W-1:0] RP_N = `TMR_W'(`RP_CYC);
   localparam logic [`TMR_W-1:0] RC_N = `TMR_W'(`RC_CYC);
   localparam logic [`TMR_W-1:0] MRD_N = `TMR_W'(`MRD_CYC);
   localparam logic [`TMR_W-1:0] XSR_N = `TMR_W'(`XSR_CYC);
   localparam logic [`TMR_W-1:0] BL_N = `TMR_W'(BURST_LEN);
   localparam logic [`TMR_W-1:0] CL_N = `TMR_W'(CAS_LAT);

   // Refuse settings the counters cannot hold
   if (BURST_LEN < 1 || BURST_LEN > `TMR_MAX || CAS_LAT < 1 || CAS_LAT > `TMR_MAX)
   begin : g_bad_param
      $error("burst length or latency out of counter range");
   end
   if (`RC_CYC > `TMR_MAX || `XSR_CYC > `TMR_MAX || `MRD_CYC < 1)
   begin : g_bad_timing
      $error("timing count out of counter range");
   end

   state_t state_reg;
   state_t state_next;
   cmd_t cmd;
   logic go;
   logic all_idle;
   bank_state_t cur;
   logic [`BANK_W-1:0] lb;

   always_comb
   begin
      state_next = state_reg;
      state_next.cke_prev = CKE_I;
      state_next.err = 1'b0;
      state_next.acc = 1'b0;
      lb = state_reg.last_bank;
      if (CMD_N_I.cs_n)
         cmd = C_NOP;
      else
         cmd = cmd_t'({CMD_N_I.ras_n, CMD_N_I.cas_n, CMD_N_I.we_n});
      for (int i = 0; i < `NUM_BANKS; i++)
      begin
         unique case (state_reg.bank[i].st)
            B_ACTIVATING, B_PRECHARGING:
            begin
               if (state_reg.bank[i].tmr <= `TMR_W'(1))
                  state_next.bank[i].st = (state_reg.bank[i].st == B_ACTIVATING) ?
                     B_ACTIVE : B_IDLE;
               else
                  state_next.bank[i].tmr = state_reg.bank[i].tmr - `TMR_W'(1);
            end
            B_READ, B_WRITE:
            begin
               if (state_reg.bank[i].brem <= `TMR_W'(1))
                  state_next.bank[i].st = B_ACTIVE;
               else
                  state_next.bank[i].brem = state_reg.bank[i].brem - `TMR_W'(1);
            end
            B_READ_AP, B_WRITE_AP:
            begin
               if (state_reg.bank[i].brem != `TMR_W'(0))
                  state_next.bank[i].brem = state_reg.bank[i].brem - `TMR_W'(1);
               else if (state_reg.bank[i].tmr <= `TMR_W'(1))
                  state_next.bank[i].st = B_IDLE;
               else
                  state_next.bank[i].tmr = state_reg.bank[i].tmr - `TMR_W'(1);
            end
            B_IDLE, B_ACTIVE: ;
         endcase
      end
      unique case (state_reg.dev)
         D_REFRESH, D_MODE_LOAD, D_PRE_ALL, D_SR_EXIT:
         begin
            if (state_reg.dev_tmr <= `TMR_W'(1))
               state_next.dev = D_NORMAL;
            else
               state_next.dev_tmr = state_reg.dev_tmr - `TMR_W'(1);
         end
         D_SELF_REF:
            if (CKE_I)
            begin
               state_next.dev = D_SR_EXIT;
               state_next.dev_tmr = XSR_N;
            end
         D_NORMAL: ;
         default:
            state_next.dev = D_NORMAL;
      endcase
      all_idle = 1'b1;
      for (int i = 0; i < `NUM_BANKS; i++)
      begin
         if (state_next.bank[i].st != B_IDLE)
            all_idle = 1'b0;
      end
      cur = state_next.bank[BA_I].st;
      go = state_reg.cke_prev && CKE_I && (state_next.dev == D_NORMAL);
      if (state_reg.cke_prev && !CKE_I && state_next.dev == D_NORMAL &&
          cmd == C_REF && all_idle)
      begin
         state_next.dev = D_SELF_REF;
         state_next.acc = 1'b1;
      end
      else if (go)
      begin
         unique case (cmd)
            C_NOP: ;
            C_ACT:
               if (cur == B_IDLE)
               begin
                  state_next.bank[BA_I].st = B_ACTIVATING;
                  state_next.bank[BA_I].tmr = RCD_N;
                  state_next.acc = 1'b1;
               end
               else
                  state_next.err = 1'b1;
            C_RD, C_WR:
               if (cur == B_ACTIVE || cur == B_READ || cur == B_WRITE)
               begin
                  if (BA_I != lb)
                     unique case (state_next.bank[lb].st)
                        B_READ:
                           if (cmd == C_WR)
                              state_next.bank[lb].st = B_ACTIVE;
                           else if (state_next.bank[lb].brem > CL_N)
                              state_next.bank[lb].brem = CL_N;
                        B_WRITE:
                           state_next.bank[lb].st = B_ACTIVE;
                        B_READ_AP, B_WRITE_AP:
                           if (state_next.bank[lb].brem != `TMR_W'(0))
                           begin
                              state_next.bank[lb].st = B_PRECHARGING;
                              state_next.bank[lb].tmr = RP_N;
                           end
                        B_IDLE, B_ACTIVATING, B_ACTIVE, B_PRECHARGING: ;
                     endcase
                  if (cmd == C_RD)
                     state_next.bank[BA_I].st = A10_I ? B_READ_AP : B_READ;
                  else
                     state_next.bank[BA_I].st = A10_I ? B_WRITE_AP : B_WRITE;
                  state_next.bank[BA_I].brem = BL_N;
                  state_next.bank[BA_I].tmr = RP_N;
                  state_next.last_bank = BA_I;
                  state_next.acc = 1'b1;
               end
               else
                  state_next.err = 1'b1;
            C_PRE:
               if (A10_I)
               begin
                  for (int i = 0; i < `NUM_BANKS; i++)
                  begin
                     if (state_next.bank[i].st inside {B_ACTIVE, B_READ, B_WRITE})
                     begin
                        state_next.bank[i].st = B_PRECHARGING;
                        state_next.bank[i].tmr = RP_N;
                     end
                     else if (state_next.bank[i].st != B_IDLE)
                        state_next.err = 1'b1;
                  end
                  state_next.dev = D_PRE_ALL;
                  state_next.dev_tmr = RP_N;
                  state_next.acc = 1'b1;
               end
               else
                  unique case (cur)
                     B_IDLE:
                        state_next.acc = 1'b1;
                     B_ACTIVE, B_READ, B_WRITE:
                     begin
                        state_next.bank[BA_I].st = B_PRECHARGING;
                        state_next.bank[BA_I].tmr = RP_N;
                        state_next.acc = 1'b1;
                     end
                     B_ACTIVATING, B_PRECHARGING, B_READ_AP, B_WRITE_AP:
                        state_next.err = 1'b1;
                  endcase
            C_BST:
               if (state_next.bank[lb].st inside {B_READ, B_WRITE})
               begin
                  state_next.bank[lb].st = B_ACTIVE;
                  state_next.acc = 1'b1;
               end
            C_REF, C_MRS:
               if (all_idle)
               begin
                  state_next.dev = (cmd == C_REF) ? D_REFRESH : D_MODE_LOAD;
                  state_next.dev_tmr = (cmd == C_REF) ? RC_N : MRD_N;
                  state_next.acc = 1'b1;
               end
               else
                  state_next.err = 1'b1;
         endcase
      end
      else if (state_reg.cke_prev && CKE_I && cmd != C_NOP)
         state_next.err = 1'b1;
   end

   always_ff @(posedge MCLK_I or posedge SYS_RST_I)
   begin
      if (SYS_RST_I)
      begin
         state_reg.cke_prev <= 1'b0;
         state_reg.dev <= D_NORMAL;
         state_reg.dev_tmr <= `TMR_RST;
         state_reg.last_bank <= `BANK_RST;
         state_reg.err <= 1'b0;
         state_reg.acc <= 1'b0;
         for (int i = 0; i < `NUM_BANKS; i++)
         begin
            state_reg.bank[i].st <= B_IDLE;
            state_reg.bank[i].tmr <= `TMR_RST;
            state_reg.bank[i].brem <= `TMR_RST;
         end
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   for (genvar g = 0; g < `NUM_BANKS; g++)
   begin : g_out
      assign BANK_STATE_O[g] = state_reg.bank[g].st;
   end
   assign DEV_STATE_O = state_reg.dev;
   assign CMD_ERR_O = state_reg.err;
   assign CMD_ACC_O = state_reg.acc;

   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (SYS_RST_I);

   a_inhibit_quiet: assert property (CMD_N_I.cs_n |=> !CMD_ERR_O && !CMD_ACC_O)
      else $error("inhibit produced a response");
   a_nop_quiet: assert property (go && cmd == C_NOP |=> !CMD_ERR_O)
      else $error("no-operation flagged as error");
   a_act_opens: assert property (go && cmd == C_ACT && cur == B_IDLE
      |=> BANK_STATE_O[$past(BA_I)] == B_ACTIVATING && CMD_ACC_O)
      else $error("activate did not open the bank");
   a_pre_idle_nop: assert property (go && cmd == C_PRE && !A10_I && cur == B_IDLE
      |=> BANK_STATE_O[$past(BA_I)] == B_IDLE && !CMD_ERR_O)
      else $error("precharge disturbed an idle bank");
   a_read_start: assert property (go && cmd == C_RD && cur == B_ACTIVE && !A10_I
      |=> BANK_STATE_O[$past(BA_I)] == B_READ)
      else $error("read did not start a burst");
   a_pre_closes: assert property (go && cmd == C_PRE && !A10_I &&
      cur inside {B_READ, B_WRITE}
      |=> BANK_STATE_O[$past(BA_I)] == B_PRECHARGING)
      else $error("precharge did not truncate the burst");
   a_bst_stops: assert property (go && cmd == C_BST &&
      state_next.bank[lb].st inside {B_READ, B_WRITE} |=> BANK_STATE_O[$past(lb)] == B_ACTIVE)
      else $error("terminate left the burst running");
   a_cke_gate: assert property (!state_reg.cke_prev && CMD_N_I.cs_n == 1'b0 &&
      DEV_STATE_O == D_NORMAL |=> !CMD_ACC_O)
      else $error("command decoded without clock enable history");
   a_act_delay: assert property (BANK_STATE_O[0] == B_ACTIVATING &&
      state_reg.bank[0].tmr == `TMR_W'(1) |=> BANK_STATE_O[0] != B_ACTIVATING)
      else $error("activating outlasted the access delay");
   a_pre_ends: assert property (BANK_STATE_O[0] == B_PRECHARGING &&
      state_reg.bank[0].tmr == `TMR_W'(1) |=> BANK_STATE_O[0] inside {B_IDLE, B_ACTIVATING})
      else $error("precharging bank did not go idle");
   a_ap_guard: assert property (go && cmd == C_ACT && cur == B_READ_AP
      |=> CMD_ERR_O ##1 BANK_STATE_O[$past(BA_I, 2)] != B_ACTIVATING)
      else $error("protected bank accepted activate");
   a_ref_busy: assert property (go && cmd == C_REF && all_idle
      |=> (DEV_STATE_O == D_REFRESH) [*2])
      else $error("refresh did not hold the device busy");
   a_busy_refuse: assert property (DEV_STATE_O == D_MODE_LOAD && state_reg.dev_tmr > 1 &&
      CKE_I && state_reg.cke_prev && cmd != C_NOP |=> CMD_ERR_O)
      else $error("busy device accepted a command");
   a_pre_all: assert property (go && cmd == C_PRE && A10_I
      |=> DEV_STATE_O == D_PRE_ALL)
      else $error("precharge all not tracked");

   c_read_burst: cover property (go && cmd == C_RD ##1 BANK_STATE_O[0] == B_READ);
   c_refresh: cover property (DEV_STATE_O == D_REFRESH ##[1:8] DEV_STATE_O == D_NORMAL);
   c_interrupt: cover property (go && cmd == C_WR && BA_I != lb &&
      state_next.bank[lb].st == B_READ);
   c_self_ref: cover property (DEV_STATE_O == D_SELF_REF ##[1:20] DEV_STATE_O == D_NORMAL);

endmodule
`default_nettype wire

/* dv/sdram_ctrl_model.sv */
// Controller model that turns bench requests into command strobes
`timescale 1ns/100ps
`default_nettype none
`include "sdram_bank_params.svh"
module sdram_ctrl_model
   import sdram_bank_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic en_i,
   input wire cmd_t op_i,
   input wire logic [`BANK_W-1:0] bank_i,
   input wire logic a10_i,
   output cmd_pins_t cmd_n_o,
   output logic [`BANK_W-1:0] ba_o,
   output logic a10_o
);
   logic tgl_reg = 1'h0;
   always @(negedge MCLK_I)
   begin
      tgl_reg <= ~tgl_reg;
   end
   always_comb
   begin
      if (!en_i)
      begin
         cmd_n_o = {1'h1, tgl_reg, ~tgl_reg, tgl_reg};
         ba_o = {tgl_reg, ~tgl_reg};
         a10_o = tgl_reg;
      end
      else
      begin
         cmd_n_o = {1'h0, op_i};
         ba_o = bank_i;
         a10_o = a10_i;
      end
   end
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the bank command tracker
`timescale 1ns/100ps
`default_nettype none
`include "sdram_bank_params.svh"
module testbench;
   import sdram_bank_pkg::*;
   logic mclk = 1'h0;
   logic rst = 1'h1;
   logic cke = 1'h1;
   logic req_en = 1'h1;
   cmd_t req_op = C_NOP;
   logic [1:0] req_bank = 2'h0;
   logic req_a10 = 1'h0;
   cmd_pins_t cmd_n;
   logic [1:0] ba;
   logic a10;
   bank_states_t bst;
   dev_state_t dst;
   logic err;
   logic acc;
   int err_total = 0;
   int checks_done = 0;

   always #12.5 mclk = ~mclk;

   sdram_ctrl_model i_ctrl (.MCLK_I(mclk), .en_i(req_en), .op_i(req_op), .bank_i(req_bank),
      .a10_i(req_a10), .cmd_n_o(cmd_n), .ba_o(ba), .a10_o(a10));

   sdram_bank_fsm #(.BURST_LEN(4), .CAS_LAT(3)) i_dut (.MCLK_I(mclk), .SYS_RST_I(rst),
      .CKE_I(cke), .CMD_N_I(cmd_n), .BA_I(ba), .A10_I(a10), .BANK_STATE_O(bst),
      .DEV_STATE_O(dst), .CMD_ERR_O(err), .CMD_ACC_O(acc));

   task automatic bad(input string msg);
      err_total++;
      $display("unexpected at %0t: %s", $time, msg);
   endtask

   task automatic chk_bank(input int b, input bank_state_t exp);
      checks_done++;
      if (bst[b] !== exp)
         bad($sformatf("bank %0d state %h want %h", b, bst[b], exp));
   endtask

   task automatic chk_dev(input dev_state_t exp);
      checks_done++;
      if (dst !== exp)
         bad($sformatf("device state %h want %h", dst, exp));
   endtask

   task automatic chk_pulse(input logic ea, input logic ee);
      checks_done++;
      if ({acc, err} !== {ea, ee})
         bad($sformatf("acc/err %b%b want %b%b", acc, err, ea, ee));
   endtask

   // Present one command; it stands until the next send or idle replaces it
   task automatic send(input cmd_t op, input logic [1:0] b, input logic a, input logic en);
      req_en = en;
      req_op = op;
      req_bank = b;
      req_a10 = a;
      @(negedge mclk);
   endtask

   task automatic idle(input int n);
      req_en = 1'h1;
      req_op = C_NOP;
      repeat (n) @(negedge mclk);
   endtask

   task automatic end_of_test;
      $display("checks %0d, mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic t_reset;
      chk_dev(D_NORMAL);
      for (int b = 0; b < 4; b++)
         chk_bank(b, B_IDLE);
      $display("test reset done");
   endtask

   task automatic t_bank_cycle;
      send(C_ACT, 2'h1, 1'h0, 1'h1);
      chk_pulse(1'h1, 1'h0);
      chk_bank(1, B_ACTIVATING);
      idle(1);
      chk_bank(1, B_ACTIVE);
      send(C_RD, 2'h1, 1'h0, 1'h1);
      chk_bank(1, B_READ);
      send(C_BST, 2'h0, 1'h0, 1'h1);
      chk_bank(1, B_ACTIVE);
      send(C_WR, 2'h1, 1'h0, 1'h1);
      chk_bank(1, B_WRITE);
      send(C_PRE, 2'h1, 1'h0, 1'h1);
      chk_pulse(1'h1, 1'h0);
      chk_bank(1, B_PRECHARGING);
      idle(1);
      chk_bank(1, B_IDLE);
      send(C_PRE, 2'h1, 1'h0, 1'h1);
      chk_pulse(1'h1, 1'h0);
      chk_bank(1, B_IDLE);
      $display("test bank cycle done");
   endtask

   task automatic t_refusals;
      send(C_ACT, 2'h0, 1'h0, 1'h1);
      idle(1);
      send(C_ACT, 2'h0, 1'h0, 1'h1);
      chk_pulse(1'h0, 1'h1);
      send(C_RD, 2'h2, 1'h0, 1'h1);
      chk_pulse(1'h0, 1'h1);
      chk_bank(2, B_IDLE);
      send(C_REF, 2'h0, 1'h0, 1'h1);
      chk_pulse(1'h0, 1'h1);
      chk_dev(D_NORMAL);
      send(C_ACT, 2'h2, 1'h0, 1'h0);
      chk_pulse(1'h0, 1'h0);
      chk_bank(2, B_IDLE);
      send(C_NOP, 2'h0, 1'h0, 1'h1);
      chk_pulse(1'h0, 1'h0);
      chk_bank(0, B_ACTIVE);
      send(C_PRE, 2'h3, 1'h1, 1'h1);
      chk_dev(D_PRE_ALL);
      chk_bank(0, B_PRECHARGING);
      idle(1);
      chk_dev(D_NORMAL);
      chk_bank(0, B_IDLE);
      $display("test refusals done");
   endtask

   task automatic t_device_wide;
      send(C_REF, 2'h0, 1'h0, 1'h1);
      chk_pulse(1'h1, 1'h0);
      chk_dev(D_REFRESH);
      send(C_ACT, 2'h0, 1'h0, 1'h1);
      chk_pulse(1'h0, 1'h1);
      chk_bank(0, B_IDLE);
      idle(1);
      chk_dev(D_REFRESH);
      idle(1);
      chk_dev(D_NORMAL);
      send(C_MRS, 2'h0, 1'h0, 1'h1);
      chk_dev(D_MODE_LOAD);
      send(C_ACT, 2'h0, 1'h0, 1'h1);
      chk_pulse(1'h0, 1'h1);
      chk_dev(D_MODE_LOAD);
      idle(1);
      chk_dev(D_NORMAL);
      $display("test device wide done");
   endtask

   task automatic t_two_banks;
      send(C_ACT, 2'h0, 1'h0, 1'h1);
      send(C_ACT, 2'h1, 1'h0, 1'h1);
      chk_bank(0, B_ACTIVE);
      chk_bank(1, B_ACTIVATING);
      idle(1);
      send(C_RD, 2'h0, 1'h1, 1'h1);
      chk_bank(0, B_READ_AP);
      send(C_PRE, 2'h0, 1'h0, 1'h1);
      chk_pulse(1'h0, 1'h1);
      send(C_ACT, 2'h0, 1'h0, 1'h1);
      chk_pulse(1'h0, 1'h1);
      idle(2);
      chk_bank(0, B_READ_AP);
      idle(1);
      chk_bank(0, B_IDLE);
      send(C_RD, 2'h1, 1'h0, 1'h1);
      send(C_ACT, 2'h0, 1'h0, 1'h1);
      chk_bank(1, B_READ);
      idle(1);
      send(C_WR, 2'h0, 1'h0, 1'h1);
      chk_bank(1, B_ACTIVE);
      chk_bank(0, B_WRITE);
      send(C_RD, 2'h1, 1'h0, 1'h1);
      chk_bank(0, B_ACTIVE);
      chk_bank(1, B_READ);
      send(C_PRE, 2'h0, 1'h1, 1'h1);
      idle(1);
      chk_bank(0, B_IDLE);
      chk_bank(1, B_IDLE);
      $display("test two banks done");
   endtask

   task automatic t_clock_enable;
      cke = 1'h0;
      send(C_ACT, 2'h3, 1'h0, 1'h1);
      chk_pulse(1'h0, 1'h0);
      chk_bank(3, B_IDLE);
      cke = 1'h1;
      send(C_ACT, 2'h3, 1'h0, 1'h1);
      chk_pulse(1'h0, 1'h0);
      send(C_ACT, 2'h3, 1'h0, 1'h1);
      chk_pulse(1'h1, 1'h0);
      chk_bank(3, B_ACTIVATING);
      idle(1);
      send(C_PRE, 2'h3, 1'h0, 1'h1);
      idle(1);
      cke = 1'h0;
      send(C_REF, 2'h0, 1'h0, 1'h1);
      chk_pulse(1'h1, 1'h0);
      chk_dev(D_SELF_REF);
      cke = 1'h1;
      idle(1);
      chk_dev(D_SR_EXIT);
      send(C_ACT, 2'h3, 1'h0, 1'h1);
      chk_pulse(1'h0, 1'h1);
      idle(3);
      chk_dev(D_SR_EXIT);
      idle(1);
      chk_dev(D_NORMAL);
      $display("test clock enable done");
   endtask

   initial
   begin
      #(25 * 2000);
      bad("watchdog expired");
      end_of_test();
   end

   initial
   begin
      repeat (6) @(negedge mclk);
      rst = 1'h0;
      idle(2);
      t_reset();
      t_bank_cycle();
      t_refusals();
      t_device_wide();
      t_two_banks();
      t_clock_enable();
      end_of_test();
   end
endmodule
`default_nettype wire
